// [rtl/port_clock_gating_run_sleep.v]
`timescale 1ns/1ps
`include "port_clock_gating_regs.vh"

module port_clock_gating_run_sleep (
  input wire clk_i,
  input wire rst_i,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  // Power mode from the power controller
  input wire [1:0] power_mode_i,
  // Port access probes from the system bus: a request aimed at each port
  input wire [2:0] port_access_i,
  // Per-port clock enables and fault answers
  output reg [2:0] port_clock_enable_o,
  output reg [2:0] port_bus_fault_o,
  output reg irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [2:0] run_port_clock_gate_reg;
  reg [2:0] sleep_port_clock_gate_reg;
  reg [2:0] deep_sleep_port_clock_gate_reg;
  reg auto_gating_select_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_mask_reg;
  reg [2:0] gate_next;
  reg [31:0] rdata_next;
  reg hit_next;
  reg [1:0] irq_set;
  reg [1:0] irq_status_next;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  // Byte lane 0 carries the gate, mask and status fields; lane 3 the auto gating bit
  wire wr_any = req & wb_we_i;
  wire wr = wr_any & wb_sel_i[0];

  // ----------------------------------------------------------------
  // Gate selection
  // ----------------------------------------------------------------
  always @* begin
    gate_next = run_port_clock_gate_reg;
    if (auto_gating_select_reg) begin
      case (power_mode_i)
        `MODE_RUN: gate_next = run_port_clock_gate_reg;
        `MODE_SLEEP: gate_next = sleep_port_clock_gate_reg;
        `MODE_DEEP: gate_next = deep_sleep_port_clock_gate_reg;
        default: gate_next = run_port_clock_gate_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0;
    hit_next = 1'b1;
    case (wb_adr_i)
      `RUN_GATE_OFFSET: rdata_next = {29'h0, run_port_clock_gate_reg};
      `SLEEP_GATE_OFFSET: rdata_next = {29'h0, sleep_port_clock_gate_reg};
      `DEEP_GATE_OFFSET: rdata_next = {29'h0, deep_sleep_port_clock_gate_reg};
      `RUN_CLOCK_CFG_OFFSET: rdata_next[`AUTO_GATING_BIT] = auto_gating_select_reg;
      `IRQ_STATUS_OFFSET: rdata_next = {30'h0, irq_status_reg};
      `IRQ_MASK_OFFSET: rdata_next = {30'h0, irq_mask_reg};
      default: hit_next = 1'b0;
    endcase
  end

  // Events: a port fault, and a sleep mode entered with its gates unused
  always @* begin
    irq_set = `IRQ_RESET;
    irq_set[`IRQ_FAULT_BIT] = |(port_access_i & ~port_clock_enable_o);
    irq_set[`IRQ_SLEEP_REJECT_BIT] = ~auto_gating_select_reg &
      (power_mode_i != `MODE_RUN);
    irq_status_next = irq_status_reg;
    if (wr && wb_adr_i == `IRQ_STATUS_OFFSET) begin
      irq_status_next = irq_status_reg & ~wb_dat_i[1:0];
    end
    // Set wins over a clear in the same cycle
    irq_status_next = irq_status_next | irq_set;
  end

  // ----------------------------------------------------------------
  // Sequential
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      run_port_clock_gate_reg <= `GATE_RESET;
      sleep_port_clock_gate_reg <= `GATE_RESET;
      deep_sleep_port_clock_gate_reg <= `GATE_RESET;
      auto_gating_select_reg <= `CFG_RESET;
      irq_status_reg <= `IRQ_RESET;
      irq_mask_reg <= `IRQ_RESET;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
      port_clock_enable_o <= `GATE_RESET;
      port_bus_fault_o <= `GATE_RESET;
      irq_o <= 1'b0;
    end else begin
      if (wr) begin
        case (wb_adr_i)
          `RUN_GATE_OFFSET: run_port_clock_gate_reg <= wb_dat_i[2:0];
          `SLEEP_GATE_OFFSET: sleep_port_clock_gate_reg <= wb_dat_i[2:0];
          `DEEP_GATE_OFFSET: deep_sleep_port_clock_gate_reg <= wb_dat_i[2:0];
          `IRQ_MASK_OFFSET: irq_mask_reg <= wb_dat_i[1:0];
          default: ;
        endcase
      end
      if (wr_any && wb_adr_i == `RUN_CLOCK_CFG_OFFSET && wb_sel_i[3]) begin
        auto_gating_select_reg <= wb_dat_i[`AUTO_GATING_BIT];
      end
      // One-cycle answer; unmapped addresses get an error
      wb_ack_o <= req & hit_next;
      wb_err_o <= req & ~hit_next;
      wb_dat_o <= (req & ~wb_we_i & hit_next) ? rdata_next : 32'h0;
      port_clock_enable_o <= gate_next;
      // Faults judged against the enables actually driven this cycle
      port_bus_fault_o <= port_access_i & ~port_clock_enable_o;
      irq_status_reg <= irq_status_next;
      irq_o <= |(irq_status_next & irq_mask_reg);
    end
  end

endmodule // port_clock_gating_run_sleep

// [rtl/port_clock_gating_regs.vh]
// Function
// - Selected gate bit one: port clock runs
// - Selected gate bit zero: port clock stopped
// - Access to gated port answers bus fault
// - Gating registers reset to all zeros
// - Run, sleep, deep-sleep registers per mode
// - Sleep registers apply only with auto gating
// - Bits 2,1,0 gate ports C, B, A
// - Bits 31:3 read-only, read as zero
// - Run register at offset 0x108
// - Sleep register at offset 0x118
// - Deep-sleep register at 0x128, same layout
`ifndef PORT_CLOCK_GATING_REGS_VH
`define PORT_CLOCK_GATING_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses from the control base)
// ----------------------------------------------------------------
`define RUN_GATE_OFFSET 12'h108
`define SLEEP_GATE_OFFSET 12'h118
`define DEEP_GATE_OFFSET 12'h128
`define RUN_CLOCK_CFG_OFFSET 12'h060
`define IRQ_STATUS_OFFSET 12'h200
`define IRQ_MASK_OFFSET 12'h204
`define ADDR_WIDTH 12

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PORT_COUNT 3
`define GATE_RESET 3'h0
`define AUTO_GATING_BIT 27
`define CFG_RESET 1'h0
`define MODE_RUN 2'h0
`define MODE_SLEEP 2'h1
`define MODE_DEEP 2'h2
`define IRQ_WIDTH 2
`define IRQ_FAULT_BIT 0
`define IRQ_SLEEP_REJECT_BIT 1
`define IRQ_RESET 2'h0

`endif

// [dv/port_clock_gating_run_sleep_properties.sv]
`timescale 1ns/1ps
module gate_props (
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic [1:0] power_mode_i,
  input wire logic [2:0] port_access_i, port_clock_enable_o, port_bus_fault_o
);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire gate = wb_adr_i == 12'h108 || wb_adr_i == 12'h118 || wb_adr_i == 12'h128;
  wire hit = gate || wb_adr_i == 12'h060 || wb_adr_i == 12'h200 || wb_adr_i == 12'h204;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  fault_answer_a:
    assert property (1 |=> port_bus_fault_o == $past(port_access_i & ~port_clock_enable_o))
    else $error("bad fault");
  reset_gated_a:
    assert property ($fell(rst_i) |-> ##1 port_clock_enable_o == 3'h0) else $error("bad reset");
  unmapped_err_a:
    assert property (req && !hit |=> wb_err_o && !wb_ack_o) else $error("no err");
  mapped_ack_a:
    assert property (req && hit |=> wb_ack_o && !wb_err_o) else $error("no ack");
  answer_pulse_a:
    assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o) else $error("long ack");
  reserved_zero_a:
    assert property (wb_ack_o && gate && !wb_we_i |-> wb_dat_o[31:3] == 29'h0) else $error("rsv");
  run_enable_a:
    assert property (wb_ack_o && wb_we_i && wb_adr_i == 12'h108 && wb_sel_i[0] && power_mode_i == 2'h0
      |=> port_clock_enable_o == $past(wb_dat_i[2:0])) else $error("bad enable");
  hold_enable_a:
    assert property (!wb_cyc_i && $past(!wb_cyc_i) && $stable(power_mode_i)
      |=> $stable(port_clock_enable_o)) else $error("enable moved");
endmodule // gate_props
bind port_clock_gating_run_sleep gate_props props (.*);

// [dv/port_clock_gating_run_sleep_test.sv]
`timescale 1ns/1ps
module port_clock_gating_run_sleep_test;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, e;
  logic [11:0] adr = 0;
  logic [31:0] dat = 0, q;
  logic [1:0] mode = 0;
  logic [2:0] acc = 0;
  wire [31:0] rdat;
  wire ack, err, irq;
  wire [2:0] en, flt;
  int miscompares = 0, checks = 0;
  always #2 clk_i = ~clk_i;
  port_clock_gating_run_sleep dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .power_mode_i(mode), .port_access_i(acc),
    .port_clock_enable_o(en), .port_bus_fault_o(flt), .irq_o(irq));
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i) {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    {cyc, stb} <= 2'h0;
  endtask
  task chk(input logic [31:0] g, x);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected at %0t: %h vs %h", $time, g, x);
    end
  endtask
  task end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task poke(input logic [2:0] p, x);
    @(posedge clk_i) acc <= p;
    @(posedge clk_i) acc <= 3'h0;
    @(posedge clk_i) chk(flt, x);
  endtask
  task settle(input logic [31:0] x);
    repeat (3) @(posedge clk_i);
    chk(en, x);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 3; i++) begin
      bus(0, 12'h108 + 12'h010 * i, 0);
      chk(q, 0);
    end
    bus(1, 12'h108, 32'hffffffff);
    bus(0, 12'h108, 0);
    chk(q, 7);
    bus(1, 12'h108, 5);
    settle(5);
    poke(2, 2);
    poke(5, 0);
    $display("test run gating done");
    bus(1, 12'h118, 3);
    mode <= 2'h1;
    settle(5);
    bus(1, 12'h060, 32'h08000000);
    settle(3);
    bus(1, 12'h128, 4);
    mode <= 2'h2;
    settle(4);
    mode <= 2'h0;
    bus(0, 12'h300, 0);
    chk(e, 1);
    bus(1, 12'h204, 3);
    settle(5);
    chk(irq, 1);
    bus(1, 12'h200, 3);
    repeat (3) @(posedge clk_i);
    chk(irq, 0);
    $display("test sleep and irq done");
    end_of_test;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    end_of_test;
  end
endmodule // port_clock_gating_run_sleep_test
